// ---- test/wid_core_model.sv ----
// Core model: takes context pushes and handler entries, returns after a set service time
`timescale 1ns/1ps
`default_nettype none
module wid_core_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Entry sequence from the controller
  input  wire logic       stack_push,
  input  wire logic [2:0] stack_slot,
  input  wire logic       handler_go,
  // Bench control
  input  wire logic [9:0] svc_cycles,
  input  wire logic       fault_req,
  // Back to the controller
  output logic            fault_evt,
  output logic            exc_return,
  // Observation
  output logic [7:0]      go_count,
  output logic            busy,
  output logic            slot_err
);
  logic [3:0] push_n;
  logic [3:0] depth;
  logic [9:0] timer;

  assign busy = (depth != 4'h0);

  // Returns only while push_n is 0 and no entry pulse is seen, since a return during stacking is dropped
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fault_evt  <= 1'b0;
      exc_return <= 1'b0;
      slot_err   <= 1'b0;
      go_count   <= 8'h00;
      push_n     <= 4'h0;
      depth      <= 4'h0;
      timer      <= 10'h000;
    end else begin
      fault_evt  <= fault_req;
      exc_return <= 1'b0;
      if (stack_push) begin
        if (stack_slot != push_n[2:0]) slot_err <= 1'b1;
        push_n <= push_n + 4'h1;
      end
      if (handler_go) begin
        if (push_n != 4'h8) slot_err <= 1'b1;
        push_n   <= 4'h0;
        go_count <= go_count + 8'h01;
        depth    <= depth + 4'h1;
        timer    <= svc_cycles;
      end else if (busy && push_n == 4'h0 && timer != 10'h000) begin
        timer <= timer - 10'h001;
      end else if (busy && push_n == 4'h0 && !exc_return) begin
        exc_return <= 1'b1;
        depth      <= depth - 4'h1;
        timer      <= svc_cycles;
      end
    end
  end
endmodule // wid_core_model
`default_nettype wire

// ---- test/wid_top_tb.sv ----
// Self-checking bench for the wake interrupt detector and arbiter
`timescale 1ns/1ps
`default_nettype none
module wid_top_tb;
  import wid_pkg::*;
  logic              core_clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wr_data = '0;
  logic              wr_en = 1'b0;
  logic              rd_en = 1'b0;
  logic [7:0]        src_in = 8'h00;
  logic [7:0]        pin_input_enable = 8'hff;
  logic [7:0]        pin_function_select = 8'h00;
  logic              deep_stop = 1'b0;
  logic              nmi_in = 1'b0;
  logic              fault_req = 1'b0;
  logic [9:0]        svc_cycles = 10'h010;
  logic [7:0]        g0;
  logic [7:0]        order [4] = '{8'h14, 8'h15, 8'h16, 8'h13};
  wire logic [DATA_W-1:0] rd_data;
  wire logic [2:0]   stack_slot;
  wire logic [7:0]   exc_num;
  wire logic [7:0]   go_count;
  wire logic         wake_req, stack_push, handler_go, fault_evt, exc_return, busy, slot_err;
  int                miscompares;
  int                check_count;

  always #5 core_clk = ~core_clk;

  wid_top dut_u (.core_clk, .rst, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .src_in,
    .pin_input_enable, .pin_function_select, .deep_stop, .nmi_in, .fault_evt, .exc_return,
    .wake_req, .stack_push, .stack_slot, .handler_go, .exc_num);
  wid_core_model core_u (.core_clk, .rst, .stack_push, .stack_slot, .handler_go,
    .svc_cycles, .fault_req, .fault_evt, .exc_return, .go_count, .busy, .slot_err);

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkw(input string what, input logic exp);
    chk(what, {31'h0, exp}, {31'h0, wake_req});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    @(posedge core_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1;
    chk(what, exp, rd_data);
  endtask

  task automatic set_in(input int i, input logic v);
    @(posedge core_clk);
    src_in[i] <= v;
  endtask

  task automatic wait_wake(input logic exp, input string what);
    int n;
    n = 0;
    // Let an output launched at this edge settle before looking
    #1;
    while (wake_req !== exp && n < 20) begin
      tick(1);
      n++;
    end
    chkw(what, exp);
    if (wake_req !== exp) wrap_up();
  endtask

  // Steps past the edge first so an earlier entry pulse is not counted twice
  task automatic wait_go(input logic [7:0] exp, input string what);
    int n;
    n = 0;
    tick(1);
    while (handler_go !== 1'b1 && n < 1000) begin
      tick(1);
      n++;
    end
    chk("handler entry", 32'h1, {31'h0, handler_go});
    if (handler_go !== 1'b1) wrap_up();
    chk(what, {24'h0, exp}, {24'h0, exc_num});
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 1000) begin
      tick(1);
      n++;
    end
    chk("core idle", 32'h0, {31'h0, busy});
    if (busy !== 1'b0) wrap_up();
  endtask

  task automatic pulse_fault();
    @(posedge core_clk);
    fault_req <= 1'b1;
    @(posedge core_clk);
    fault_req <= 1'b0;
  endtask

  initial begin
    miscompares = 0;
    check_count = 0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    rd(OFS_SET_EN, 32'h0, "enable reset");
    rd(OFS_CLR_PEND, 32'h0, "pending reset");
    rd(OFS_MODE_A, 32'h0, "mode reset");
    wr(12'h300, 32'hffffffff);
    rd(12'h300, 32'h0, "unmapped");
    wr(OFS_PRI_0, 32'hffffffff);
    rd(OFS_PRI_0, 32'he0e0e0e0, "priority bits");
    wr(OFS_APP_CTRL, 32'h00000500);
    rd(OFS_APP_CTRL, 32'hfa050000, "keyless grouping");
    wr(OFS_APP_CTRL, 32'h05fa0500);
    rd(OFS_APP_CTRL, 32'hfa050500, "grouping");
    wr(OFS_APP_CTRL, 32'h05fa0000);
    $display("test registers done");
    // Mask, set levels, clear held requests, then enable
    wr(OFS_GMASK, 32'h1);
    wr(OFS_MODE_A, 32'h0004040c);
    wr(OFS_MODE_B, 32'h00000004);
    for (int i = 0; i < 5; i++) wr(OFS_REQ_CLEAR, i);
    wr(OFS_MODE_A, 32'h0005050d);
    wr(OFS_MODE_B, 32'h00000005);
    rd(OFS_MODE_A, 32'h0005050d, "mode a");
    set_in(0, 1'b1);
    set_in(0, 1'b0);
    wait_wake(1'b1, "edge request");
    tick(10);
    chkw("edge held", 1'b1);
    wr(OFS_REQ_CLEAR, 32'h9);
    tick(4);
    chkw("foreign code", 1'b1);
    wr(OFS_REQ_CLEAR, 32'h0);
    wait_wake(1'b0, "edge cleared");
    set_in(0, 1'b1);
    set_in(0, 1'b0);
    wait_wake(1'b1, "fresh edge");
    wr(OFS_REQ_CLEAR, 32'h0);
    wait_wake(1'b0, "fresh cleared");
    set_in(1, 1'b1);
    wait_wake(1'b1, "level request");
    tick(6);
    chkw("level held", 1'b1);
    set_in(1, 1'b0);
    wait_wake(1'b0, "level removed");
    @(posedge core_clk);
    pin_input_enable[2] <= 1'b0;
    set_in(2, 1'b1);
    tick(8);
    chkw("buffer off", 1'b0);
    @(posedge core_clk);
    pin_input_enable[2] <= 1'b1;
    deep_stop <= 1'b1;
    tick(8);
    chkw("deep stop", 1'b0);
    @(posedge core_clk);
    pin_function_select[2] <= 1'b1;
    wait_wake(1'b1, "deep stop function");
    @(posedge core_clk);
    deep_stop <= 1'b0;
    pin_function_select[2] <= 1'b0;
    tick(8);
    chkw("run mode", 1'b1);
    set_in(2, 1'b0);
    wait_wake(1'b0, "pass released");
    set_in(4, 1'b1);
    wait_wake(1'b1, "peripheral edge");
    set_in(4, 1'b0);
    tick(8);
    chkw("peripheral held", 1'b1);
    wr(OFS_REQ_CLEAR, 32'h4);
    wait_wake(1'b0, "peripheral cleared");
    wr(OFS_CLR_PEND, 32'hff);
    $display("test detector done");
    // Low priority bits differ so that using them would change the order
    wr(OFS_PRI_0, 32'h60000000);
    wr(OFS_PRI_1, 32'h00415f40);
    wr(OFS_SET_PEND, 32'h81);
    wr(OFS_CLR_PEND, 32'h81);
    rd(OFS_CLR_PEND, 32'h0, "clear pending");
    wr(OFS_SET_PEND, 32'h78);
    rd(OFS_CLR_PEND, 32'h78, "set pending");
    wr(OFS_SET_EN, 32'h78);
    wr(OFS_CLR_EN, 32'h08);
    rd(OFS_SET_EN, 32'h70, "enables");
    wr(OFS_SET_EN, 32'h08);
    tick(30);
    chk("masked entries", 32'h0, {24'h0, go_count});
    wr(OFS_GMASK, 32'h0);
    foreach (order[k]) wait_go(order[k], "arbitration order");
    wait_idle();
    $display("test arbitration done");
    @(posedge core_clk);
    svc_cycles <= 10'h0c8;
    wr(OFS_SET_PEND, 32'h08);
    wait_go(8'h13, "base handler");
    wr(OFS_SET_PEND, 32'h10);
    wait_go(8'h14, "preempting irq");
    @(posedge core_clk);
    nmi_in <= 1'b1;
    tick(4);
    @(posedge core_clk);
    nmi_in <= 1'b0;
    wait_go(EXC_NMI, "nmi");
    wait_idle();
    @(posedge core_clk);
    svc_cycles <= 10'h010;
    wr(OFS_GMASK, 32'h1);
    pulse_fault();
    wait_go(EXC_HARD, "masked fault");
    wait_idle();
    wr(OFS_GMASK, 32'h0);
    pulse_fault();
    wait_go(EXC_FAULT, "unmasked fault");
    wait_idle();
    $display("test preemption done");
    // Group bits [7:6] only: priorities 3 and 2 share a group
    wr(OFS_APP_CTRL, 32'h05fa0500);
    @(posedge core_clk);
    svc_cycles <= 10'h03c;
    wr(OFS_SET_PEND, 32'h08);
    wait_go(8'h13, "group base");
    // The core counts an entry one edge after the pulse, so sample past it
    wr(OFS_SET_PEND, 32'h10);
    g0 = go_count;
    tick(30);
    chk("same group", {24'h0, g0}, {24'h0, go_count});
    wait_go(8'h14, "after return");
    wait_idle();
    chk("stack order", 32'h0, {31'h0, slot_err});
    $display("test grouping done");
    wrap_up();
  end
endmodule // wid_top_tb
`default_nettype wire

// ---- verilog/wid_pkg.sv ----
// Package: constants, register map and state types of the wake interrupt detector and arbiter
package wid_pkg;

  localparam int NUM_SRC = 8;
  localparam int PRI_W   = 3;
  localparam int PRI_LSB = 5;
  localparam int ADDR_W  = 12;
  localparam int DATA_W  = 32;
  localparam int CODE_W  = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_REQ_CLEAR = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_MODE_A    = 12'h020;
  localparam logic [ADDR_W-1:0] OFS_MODE_B    = 12'h024;
  localparam logic [ADDR_W-1:0] OFS_SET_EN    = 12'h100;
  localparam logic [ADDR_W-1:0] OFS_CLR_EN    = 12'h180;
  localparam logic [ADDR_W-1:0] OFS_SET_PEND  = 12'h200;
  localparam logic [ADDR_W-1:0] OFS_CLR_PEND  = 12'h280;
  localparam logic [ADDR_W-1:0] OFS_PRI_0     = 12'h400;
  localparam logic [ADDR_W-1:0] OFS_PRI_1     = 12'h404;
  localparam logic [ADDR_W-1:0] OFS_APP_CTRL  = 12'hd0c;
  localparam logic [ADDR_W-1:0] OFS_GMASK     = 12'hf00;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 12'hf04;

  // Field layout
  localparam int MODE_EN_BIT  = 0;
  localparam int MODE_LVL_LSB = 2;
  localparam int PRIGRP_LSB   = 8;
  localparam int KEY_LSB      = 16;
  localparam logic [15:0] APP_KEY_WR = 16'h05fa;
  localparam logic [15:0] APP_KEY_RD = 16'hfa05;
  localparam int ST_NMI_BIT   = 8;
  localparam int ST_HARD_BIT  = 9;
  localparam int ST_FAULT_BIT = 10;
  localparam int ST_EXC_LSB   = 16;

  // Active level codes; peripheral sources force bit 1 (edge only)
  localparam logic [1:0] LVL_LOW  = 2'h0;
  localparam logic [1:0] LVL_HIGH = 2'h1;
  localparam logic [1:0] LVL_FALL = 2'h2;
  localparam logic [1:0] LVL_RISE = 2'h3;
  localparam logic [NUM_SRC-1:0] SRC_IS_PIN = 8'h0f;

  // Reset values
  localparam logic [1:0]       LVL_RST  = 2'h0;
  localparam logic [PRI_W-1:0] PRI_RST  = 3'h0;
  localparam logic [2:0]       GRP_RST  = 3'h0;
  localparam logic             GMASK_RST = 1'b0;

  // Exception numbers and ranks (lower rank is more urgent)
  localparam logic [7:0] EXC_NMI      = 8'h02;
  localparam logic [7:0] EXC_HARD     = 8'h03;
  localparam logic [7:0] EXC_FAULT    = 8'h06;
  localparam logic [7:0] EXC_IRQ_BASE = 8'h10;
  localparam logic [3:0] RANK_NMI   = 4'h0;
  localparam logic [3:0] RANK_HARD  = 4'h1;
  localparam logic [3:0] RANK_FAULT = 4'h2;
  localparam logic [3:0] RANK_IRQ   = 4'h2;
  localparam logic [3:0] RANK_IDLE  = 4'hf;

  // Stack slots 0..7: r0 r1 r2 r3 r12 lr pc psr
  localparam logic [2:0] STACK_LAST = 3'h7;

  typedef enum logic [1:0] {WID_IDLE, WID_STACK, WID_ENTER} wid_fsm_t;

  typedef struct packed {
    logic [NUM_SRC-1:0]            mode_en;
    logic [NUM_SRC-1:0][1:0]       mode_lvl;
    logic [NUM_SRC-1:0]            sync1;
    logic [NUM_SRC-1:0]            sync2;
    logic [NUM_SRC-1:0]            prev;
    logic [NUM_SRC-1:0]            held;
    logic [NUM_SRC-1:0]            irq_en;
    logic [NUM_SRC-1:0]            pend;
    logic [NUM_SRC-1:0]            act;
    logic [NUM_SRC-1:0][PRI_W-1:0] pri;
    logic [2:0]                    prigroup;
    logic                          gmask;
    logic                          nmi_s1;
    logic                          nmi_s2;
    logic                          nmi_prev;
    logic                          nmi_pend;
    logic                          nmi_act;
    logic                          hf_pend;
    logic                          hf_act;
    logic                          flt_pend;
    logic                          flt_act;
    wid_fsm_t                      fsm;
    logic [2:0]                    slot;
    logic [2:0]                    slot_out;
    logic [7:0]                    exc_num;
    logic                          stack_push;
    logic                          handler_go;
    logic                          wake_req;
    logic [DATA_W-1:0]             rd_data;
  } wid_state_t;

endpackage

// ---- verilog/wid_top.sv ----
// Wake interrupt detector, nested priority arbiter and exception entry sequencer
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module wid_top (
  // Clock and reset
  input  wire logic                             core_clk,
  input  wire logic                             rst,
  // Register port
  input  wire logic [wid_pkg::ADDR_W-1:0]       addr,
  input  wire logic [wid_pkg::DATA_W-1:0]       wr_data,
  input  wire logic                             wr_en,
  input  wire logic                             rd_en,
  output logic      [wid_pkg::DATA_W-1:0]       rd_data,
  // Interrupt sources and pin control
  input  wire logic [wid_pkg::NUM_SRC-1:0]      src_in,
  input  wire logic [wid_pkg::NUM_SRC-1:0]      pin_input_enable,
  input  wire logic [wid_pkg::NUM_SRC-1:0]      pin_function_select,
  input  wire logic                             deep_stop,
  input  wire logic                             nmi_in,
  // Core side
  input  wire logic                             fault_evt,
  input  wire logic                             exc_return,
  output logic                                  wake_req,
  output logic                                  stack_push,
  output logic      [2:0]                       stack_slot,
  output logic                                  handler_go,
  output logic      [7:0]                       exc_num
);
  import wid_pkg::*;

  wid_state_t s;
  wid_state_t n;

  logic [NUM_SRC-1:0] cg_line;
  logic [NUM_SRC-1:0] held_nx;
  logic [NUM_SRC-1:0] edge_mode;
  logic [NUM_SRC-1:0] clr_hit;
  logic               clr_wr;
  logic [PRI_W-1:0]   grp_mask;

  assign clr_wr = wr_en && (addr == OFS_REQ_CLEAR);

  // Group part keeps only priority bits above the grouping point
  always_comb begin
    for (int b = 0; b < PRI_W; b++) begin
      grp_mask[b] = ((PRI_LSB + b) > int'(s.prigroup));
    end
  end

  for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
    logic       pass;
    logic [1:0] lvl;
    logic       rise;
    logic       fall;
    logic       hit_edge;
    // Function select only matters in deep stop
    assign pass = pin_input_enable[i] & (~deep_stop | pin_function_select[i]);
    // Peripheral sources are edge only: low maps to falling, high to rising
    assign lvl  = SRC_IS_PIN[i] ? s.mode_lvl[i] : (s.mode_lvl[i] | LVL_FALL);
    assign rise = pass & s.sync2[i] & ~s.prev[i];
    assign fall = pass & ~s.sync2[i] & s.prev[i];
    assign edge_mode[i] = lvl[1];
    assign hit_edge = (lvl == LVL_RISE) ? rise : fall;
    assign clr_hit[i] = clr_wr && (wr_data[CODE_W-1:0] == CODE_W'(i));
    // A new edge in the clearing cycle wins over the clear
    assign held_nx[i] = (s.mode_en[i] & lvl[1] & hit_edge) | (s.held[i] & ~clr_hit[i]);
    // Disabled sources pass straight through as a high-active line
    assign cg_line[i] = ~s.mode_en[i] ? (pass & s.sync2[i]) :
                        lvl[1] ? s.held[i] :
                        (pass & (s.sync2[i] == lvl[0]));
  end

  // Arbitration among enabled pending sources
  logic             best_ok;
  logic [2:0]       best_idx;
  logic [PRI_W-1:0] best_pri;
  logic [3:0]       run_rank;
  logic [3:0]       cand_rank;
  logic [3:0]       irq_rank;
  logic             ret_nmi;
  logic             ret_hf;
  logic             ret_flt;
  logic [NUM_SRC-1:0] ret_irq;

  always_comb begin
    logic [3:0] r;
    r = RANK_IDLE;
    best_ok  = 1'b0;
    best_idx = '0;
    best_pri = '1;
    for (int i = 0; i < NUM_SRC; i++) begin
      // Strict compare keeps the lowest number on a tie
      if (s.pend[i] && s.irq_en[i] && (!best_ok || s.pri[i] < best_pri)) begin
        best_ok  = 1'b1;
        best_idx = 3'(i);
        best_pri = s.pri[i];
      end
    end
    irq_rank = RANK_IRQ + {1'b0, best_pri & grp_mask};
    // Running level is the most urgent active handler
    run_rank = RANK_IDLE;
    ret_nmi = 1'b0;
    ret_hf  = 1'b0;
    ret_flt = 1'b0;
    ret_irq = '0;
    if (s.nmi_act) begin
      run_rank = RANK_NMI;
      ret_nmi  = 1'b1;
    end else if (s.hf_act) begin
      run_rank = RANK_HARD;
      ret_hf   = 1'b1;
    end else if (s.flt_act) begin
      run_rank = RANK_FAULT;
      ret_flt  = 1'b1;
    end else begin
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
        r = RANK_IRQ + {1'b0, s.pri[i] & grp_mask};
        if (s.act[i] && r <= run_rank) begin
          run_rank = r;
          ret_irq  = '0;
          ret_irq[i] = 1'b1;
        end
      end
    end
    if (s.nmi_pend)
      cand_rank = RANK_NMI;
    else if (s.hf_pend)
      cand_rank = RANK_HARD;
    else if (s.flt_pend && !s.gmask)
      cand_rank = RANK_FAULT;
    else if (best_ok && !s.gmask)
      cand_rank = irq_rank;
    else
      cand_rank = RANK_IDLE;
  end

  always_comb begin
    n = s;
    n.stack_push = 1'b0;
    n.handler_go = 1'b0;
    n.rd_data    = '0;
    n.sync1      = src_in;
    n.sync2      = s.sync1;
    n.prev       = s.sync2;
    n.nmi_s1     = nmi_in;
    n.nmi_s2     = s.nmi_s1;
    n.nmi_prev   = s.nmi_s2;
    n.held       = held_nx;
    n.wake_req   = |cg_line;

    if (wr_en) begin
      case (addr)
        OFS_MODE_A, OFS_MODE_B: begin
          for (int j = 0; j < 4; j++) begin
            n.mode_en[(addr == OFS_MODE_B ? 4 : 0) + j]  = wr_data[8*j + MODE_EN_BIT];
            n.mode_lvl[(addr == OFS_MODE_B ? 4 : 0) + j] = wr_data[8*j + MODE_LVL_LSB +: 2];
          end
        end
        OFS_SET_EN:   n.irq_en = s.irq_en | wr_data[NUM_SRC-1:0];
        OFS_CLR_EN:   n.irq_en = s.irq_en & ~wr_data[NUM_SRC-1:0];
        OFS_SET_PEND: n.pend   = s.pend | wr_data[NUM_SRC-1:0];
        OFS_CLR_PEND: n.pend   = s.pend & ~wr_data[NUM_SRC-1:0];
        OFS_PRI_0, OFS_PRI_1: begin
          for (int j = 0; j < 4; j++) begin
            n.pri[(addr == OFS_PRI_1 ? 4 : 0) + j] = wr_data[8*j + PRI_LSB +: PRI_W];
          end
        end
        OFS_APP_CTRL: begin
          if (wr_data[KEY_LSB +: 16] == APP_KEY_WR)
            n.prigroup = wr_data[PRIGRP_LSB +: 3];
        end
        OFS_GMASK:    n.gmask = wr_data[0];
        default:      n.gmask = s.gmask;
      endcase
    end

    if (rd_en) begin
      case (addr)
        OFS_MODE_A, OFS_MODE_B: begin
          for (int j = 0; j < 4; j++) begin
            n.rd_data[8*j + MODE_EN_BIT]       = s.mode_en[(addr == OFS_MODE_B ? 4 : 0) + j];
            n.rd_data[8*j + MODE_LVL_LSB +: 2] = s.mode_lvl[(addr == OFS_MODE_B ? 4 : 0) + j];
          end
        end
        OFS_SET_EN, OFS_CLR_EN:     n.rd_data[NUM_SRC-1:0] = s.irq_en;
        OFS_SET_PEND, OFS_CLR_PEND: n.rd_data[NUM_SRC-1:0] = s.pend;
        OFS_PRI_0, OFS_PRI_1: begin
          for (int j = 0; j < 4; j++) begin
            n.rd_data[8*j + PRI_LSB +: PRI_W] = s.pri[(addr == OFS_PRI_1 ? 4 : 0) + j];
          end
        end
        OFS_APP_CTRL: begin
          n.rd_data[KEY_LSB +: 16]   = APP_KEY_RD;
          n.rd_data[PRIGRP_LSB +: 3] = s.prigroup;
        end
        OFS_GMASK:  n.rd_data[0] = s.gmask;
        OFS_STATUS: begin
          n.rd_data[NUM_SRC-1:0]    = s.act;
          n.rd_data[ST_NMI_BIT]     = s.nmi_act;
          n.rd_data[ST_HARD_BIT]    = s.hf_act;
          n.rd_data[ST_FAULT_BIT]   = s.flt_act;
          n.rd_data[ST_EXC_LSB +: 8] = s.exc_num;
        end
        default: n.rd_data = '0;
      endcase
    end

    // Hardware set events win over software clears in the same cycle
    n.pend = n.pend | (cg_line & ~s.act);

    case (s.fsm)
      WID_IDLE: begin
        if (exc_return) begin
          // Return and acceptance never share a cycle, so the running level is stable
          n.nmi_act = s.nmi_act & ~ret_nmi;
          n.hf_act  = s.hf_act & ~ret_hf;
          n.flt_act = s.flt_act & ~ret_flt;
          n.act     = s.act & ~ret_irq;
        end else if (cand_rank < run_rank) begin
          n.fsm  = WID_STACK;
          n.slot = '0;
          if (cand_rank == RANK_NMI && s.nmi_pend) begin
            n.nmi_pend = 1'b0;
            n.nmi_act  = 1'b1;
            n.exc_num  = EXC_NMI;
          end else if (s.hf_pend) begin
            n.hf_pend = 1'b0;
            n.hf_act  = 1'b1;
            n.exc_num = EXC_HARD;
          end else if (s.flt_pend && !s.gmask) begin
            n.flt_pend = 1'b0;
            n.flt_act  = 1'b1;
            n.exc_num  = EXC_FAULT;
          end else begin
            n.pend[best_idx] = 1'b0;
            n.act[best_idx]  = 1'b1;
            n.exc_num        = EXC_IRQ_BASE + {5'h00, best_idx};
          end
        end
      end
      WID_STACK: begin
        // Context is pushed one word a cycle; no late arrival is taken meanwhile
        n.stack_push = 1'b1;
        n.slot_out   = s.slot;
        n.slot       = s.slot + 3'h1;
        if (s.slot == STACK_LAST)
          n.fsm = WID_ENTER;
      end
      WID_ENTER: begin
        n.handler_go = 1'b1;
        n.fsm        = WID_IDLE;
      end
      default: n.fsm = WID_IDLE;
    endcase

    // Events land after entry clears its flag, so one arriving then is kept
    if (s.nmi_s2 && !s.nmi_prev)
      n.nmi_pend = 1'b1;
    if (fault_evt) begin
      if (s.gmask || s.flt_act)
        n.hf_pend = 1'b1;
      else
        n.flt_pend = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s          <= '0;
      s.mode_lvl <= {NUM_SRC{LVL_RST}};
      s.pri      <= {NUM_SRC{PRI_RST}};
      s.prigroup <= GRP_RST;
      s.gmask    <= GMASK_RST;
      s.fsm      <= WID_IDLE;
    end else begin
      s <= n;
    end
  end

  assign rd_data    = s.rd_data;
  assign wake_req   = s.wake_req;
  assign stack_push = s.stack_push;
  assign stack_slot = s.slot_out;
  assign handler_go = s.handler_go;
  assign exc_num    = s.exc_num;

  // Checks
  property p_held_keep;
    @(posedge core_clk) disable iff (rst)
      (s.held[0] && !clr_hit[0]) |=> s.held[0];
  endproperty
  a_held_keep: assert property (p_held_keep) else $error("held request lost");

  property p_held_clear;
    @(posedge core_clk) disable iff (rst)
      (s.held[0] && clr_hit[0] && !(held_nx[0] && !s.held[0]) && !g_src[0].hit_edge)
        |=> !s.held[0];
  endproperty
  a_held_clear: assert property (p_held_clear) else $error("clear code ignored");

  property p_bad_code;
    @(posedge core_clk) disable iff (rst)
      (clr_wr && wr_data[CODE_W-1:0] >= CODE_W'(NUM_SRC))
        |=> ((s.held & $past(s.held)) == $past(s.held));
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("unmatched code cleared");

  property p_line_out;
    @(posedge core_clk) disable iff (rst)
      (|(s.held & s.mode_en & edge_mode)) |=> wake_req;
  endproperty
  a_line_out: assert property (p_line_out) else $error("held request not driven");

  property p_masked;
    @(posedge core_clk) disable iff (rst)
      (s.gmask && !s.nmi_pend && !s.hf_pend && s.fsm == WID_IDLE) |=> s.fsm == WID_IDLE;
  endproperty
  a_masked: assert property (p_masked) else $error("entry under global mask");

  property p_escalate;
    @(posedge core_clk) disable iff (rst)
      (fault_evt && s.gmask) |=> (s.hf_pend || s.hf_act);
  endproperty
  a_escalate: assert property (p_escalate) else $error("fault not escalated");

  property p_stacking;
    @(posedge core_clk) disable iff (rst)
      (s.fsm == WID_STACK && $past(s.fsm) == WID_IDLE)
        |=> (stack_push [*8]) ##1 (handler_go && !stack_push);
  endproperty
  a_stacking: assert property (p_stacking) else $error("stacking sequence wrong");

  property p_set_pend;
    @(posedge core_clk) disable iff (rst)
      (wr_en && addr == OFS_SET_PEND && wr_data[0]) |=> s.pend[0];
  endproperty
  a_set_pend: assert property (p_set_pend) else $error("set-pending lost");

  property p_clr_pend;
    @(posedge core_clk) disable iff (rst)
      (wr_en && addr == OFS_CLR_PEND && wr_data[0] && !cg_line[0]) |=> !s.pend[0];
  endproperty
  a_clr_pend: assert property (p_clr_pend) else $error("clear-pending ignored");

  property p_fresh_edge;
    @(posedge core_clk) disable iff (rst)
      (s.mode_en[0] && edge_mode[0] && g_src[0].hit_edge) |=> s.held[0];
  endproperty
  a_fresh_edge: assert property (p_fresh_edge) else $error("active edge not held");

  property p_wake_drop;
    @(posedge core_clk) disable iff (rst)
      (cg_line == '0) |=> !wake_req;
  endproperty
  a_wake_drop: assert property (p_wake_drop) else $error("request line stuck high");

  property p_level_on;
    @(posedge core_clk) disable iff (rst)
      (s.mode_en[1] && !edge_mode[1] && g_src[1].pass && (s.sync2[1] == g_src[1].lvl[0]))
        |=> wake_req;
  endproperty
  a_level_on: assert property (p_level_on) else $error("active level not forwarded");

  property p_nmi_take;
    @(posedge core_clk) disable iff (rst)
      (s.nmi_pend && !s.nmi_act && s.fsm == WID_IDLE && !exc_return)
        |=> (s.fsm == WID_STACK && exc_num == EXC_NMI);
  endproperty
  a_nmi_take: assert property (p_nmi_take) else $error("nmi not taken at once");

  c_irq_entry: cover property (@(posedge core_clk) disable iff (rst)
    handler_go && exc_num >= EXC_IRQ_BASE);
  c_nmi_nested: cover property (@(posedge core_clk) disable iff (rst)
    handler_go && exc_num == EXC_NMI && (|s.act));
  c_held_cleared: cover property (@(posedge core_clk) disable iff (rst)
    s.held[0] ##1 !s.held[0]);
  c_group_wait: cover property (@(posedge core_clk) disable iff (rst)
    s.act[3] && s.pend[4] && s.irq_en[4] && s.fsm == WID_IDLE);

endmodule // wid_top
`default_nettype wire
